// *** rtl/dcc_pkg.sv ***
// Constants for the dual comparator control block
package dcc_pkg;

	// Register indices on the plain register port
	localparam logic [1:0] ADDR_CTRL_STATUS = 2'h0;
	localparam logic [1:0] ADDR_IRQ_CONTROL = 2'h1;
	localparam logic [1:0] ADDR_DIRECTION   = 2'h2;
	localparam logic [1:0] ADDR_PORT_READ   = 2'h3;

	// Control/status field positions
	localparam int SECOND_RESULT_BIT = 7;
	localparam int FIRST_RESULT_BIT  = 6;
	localparam int SECOND_INV_BIT    = 5;
	localparam int FIRST_INV_BIT     = 4;
	localparam int INPUT_SWITCH_BIT  = 3;
	localparam int MODE_LSB          = 0;
	localparam int MODE_WIDTH        = 3;

	// Interrupt control field positions
	localparam int FLAG_BIT          = 0;
	localparam int CHANGE_ENABLE_BIT = 1;
	localparam int PERIPH_ENABLE_BIT = 2;
	localparam int GLOBAL_ENABLE_BIT = 3;

	// Result pin positions in the port
	localparam int RESULT_PIN_ONE_POS = 1;
	localparam int RESULT_PIN_TWO_POS = 2;

	// Reset values
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam logic [3:0] IRQ_RESET       = 4'h0;
	localparam logic [7:0] DIRECTION_RESET = 8'hff;

	// Modes
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [2:0] MODE_VREF  = 3'h6;
	localparam logic [2:0] MODE_OFF   = 3'h7;

	// Mode entry: {comparator on [1:0], pin output, vref, analog pin mask [7:0]}
	localparam int ENTRY_WIDTH = 12;
	localparam logic [7:0][ENTRY_WIDTH-1:0] MODE_TABLE = {
		12'h000, // 111: both off, pins digital
		12'hd78, // 110: reference on non-inverting, switched inverting inputs
		12'he70, // 101: common reference, results on pins
		12'hc70, // 100: common reference
		12'he78, // 011: two independent, results on pins
		12'hc78, // 010: two independent
		12'h460, // 001: one comparator
		12'h07e  // 000: reset, pins 1 to 6 analog, off
	};

endpackage : dcc_pkg

// *** rtl/dcc_top.sv ***
// Dual comparator control, status, change detect and pin routing
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ns
// Summary of operation
// RL1: Bit 7 reads comparator two result, flipped when its invert bit set.
// RL2: Bit 6 reads comparator one result, flipped when its invert bit set.
// RL3: Bits 5 and 4 invert comparator two and one outputs.
// RL4: In mode 110 the switch bit picks alternate or default inverting pins.
// RL5: Three-bit mode decodes to eight multiplexer configurations.
// RL6: Mode 110 puts the internal reference on both non-inverting inputs.
// RL7: Mode 111 turns both comparators off.
// RL8: Reset clears the register; mode 000, pins 1 to 6 analog, comparators off.
// RL9: Result bits are read only; writes do not change them.
// RL10: Output modes drive result pins straight from comparators, unsynchronised.
// RL11: Port direction bits still act as result pin output enables.
// RL12: Flag sets whenever either comparator output changes.
// RL13: Writing 0 clears the flag, writing 1 sets it.
// RL14: Request needs change, peripheral and global enables; flag sets regardless.
// RL15: Mismatch keeps setting flag; register access ends the mismatch.
// RL16: A change racing a register read still sets the flag; the race is closed.
// RL17: In sleep comparators keep working and enabled change wakes device.
// RL18: Waking from sleep leaves the register unchanged.
// RL19: Software should mask the interrupt while changing mode.
// RL20: Port reads return 0 at pins configured as analog.
// RL21: Raw outputs are synchronised to the core clock first.
// RL22: Synced outputs compare against a copy latched on each access.
module dcc_top #(
	parameter int SYNC_STAGES = 2
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Register port
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	// Analog comparator side
	input  wire logic [1:0] comparator_raw,
	output logic      [1:0] comparator_power,
	output logic            noninv_vref_select,
	output logic            inverting_alt_select,
	output logic      [7:0] analog_pin_mask,
	// Port pins
	input  wire logic [7:0] port_pin_in,
	output logic      [1:0] result_pin_out,
	output logic      [1:0] result_pin_oe,
	// Power and interrupt
	input  wire logic       sleep,
	output logic            wake_request,
	output logic            irq_request
);

	////////////////////////////////////////////////////////////////////////////////

	// Fewer than two stages leaves the raw comparator metastable at the flag logic
	if (SYNC_STAGES < 2) begin : g_bad_sync
		$error("SYNC_STAGES must be at least 2");
	end

	typedef struct packed {
		logic [SYNC_STAGES-1:0] sync_one;
		logic [SYNC_STAGES-1:0] sync_two;
		logic [1:0]             last_seen;
		logic                   second_inv;
		logic                   first_inv;
		logic                   input_switch;
		logic [2:0]             comparator_mode_field;
		logic                   comparator_change_flag;
		logic                   comparator_change_enable;
		logic                   peripheral_irq_enable;
		logic                   global_irq_enable;
		logic [7:0]             port_direction_bits;
		logic [7:0]             rdata;
	} dcc_state_type;

	dcc_state_type state;
	dcc_state_type next_state;

	logic [dcc_pkg::ENTRY_WIDTH-1:0] mode_entry;
	logic [1:0]                      mode_on;
	logic                            mode_pin_out;
	logic [1:0]                      gated_raw;
	logic [1:0]                      invert;
	logic [1:0]                      adjusted;
	logic                            status_access;
	logic                            mismatch;
	logic [7:0]                      status_value;
	logic [7:0]                      irq_value;
	logic [7:0]                      port_value;

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode

	always_comb begin
		mode_entry = dcc_pkg::MODE_TABLE[state.comparator_mode_field]; // [RL5]
	end

	assign mode_on         = mode_entry[11:10]; // [RL7] [RL8]
	assign mode_pin_out    = mode_entry[9];
	assign analog_pin_mask = mode_entry[7:0];
	assign comparator_power = mode_on; // [RL17]
	assign noninv_vref_select = (state.comparator_mode_field == dcc_pkg::MODE_VREF); // [RL6]
	assign inverting_alt_select = noninv_vref_select & state.input_switch; // [RL4]

	// Powered-down comparators read as low
	assign gated_raw = comparator_raw & mode_on;
	assign invert    = {state.second_inv, state.first_inv}; // [RL3]

	////////////////////////////////////////////////////////////////////////////////
	// Result pins, one per comparator

	for (genvar i = 0; i < 2; i++) begin : g_pin
		localparam int POS = (i == 0) ? dcc_pkg::RESULT_PIN_ONE_POS
		                              : dcc_pkg::RESULT_PIN_TWO_POS;
		// Straight path, no flop: pin tracks the comparator
		assign result_pin_out[i] = mode_pin_out & (gated_raw[i] ^ invert[i]); // [RL10]
		// Direction bit 1 means input, so the pin is released
		assign result_pin_oe[i]  = mode_pin_out & ~state.port_direction_bits[POS]; // [RL11]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised, polarity adjusted results

	assign adjusted = {state.sync_two[SYNC_STAGES-1], state.sync_one[SYNC_STAGES-1]} ^ invert;

	assign status_access = (reg_write | reg_read) & (reg_addr == dcc_pkg::ADDR_CTRL_STATUS);
	assign mismatch      = (adjusted != state.last_seen); // [RL22]

	always_comb begin
		status_value = '0;
		status_value[dcc_pkg::SECOND_RESULT_BIT] = adjusted[1]; // [RL1]
		status_value[dcc_pkg::FIRST_RESULT_BIT]  = adjusted[0]; // [RL2]
		status_value[dcc_pkg::SECOND_INV_BIT]    = state.second_inv;
		status_value[dcc_pkg::FIRST_INV_BIT]     = state.first_inv;
		status_value[dcc_pkg::INPUT_SWITCH_BIT]  = state.input_switch;
		status_value[dcc_pkg::MODE_LSB +: dcc_pkg::MODE_WIDTH] = state.comparator_mode_field;
	end

	always_comb begin
		irq_value = '0;
		irq_value[dcc_pkg::FLAG_BIT]          = state.comparator_change_flag;
		irq_value[dcc_pkg::CHANGE_ENABLE_BIT] = state.comparator_change_enable;
		irq_value[dcc_pkg::PERIPH_ENABLE_BIT] = state.peripheral_irq_enable;
		irq_value[dcc_pkg::GLOBAL_ENABLE_BIT] = state.global_irq_enable;
	end

	// Analog pins read low
	assign port_value = port_pin_in & ~analog_pin_mask; // [RL20]

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_state = state;

		// First stage feeds only the second
		next_state.sync_one = {state.sync_one[SYNC_STAGES-2:0], gated_raw[0]}; // [RL21]
		next_state.sync_two = {state.sync_two[SYNC_STAGES-2:0], gated_raw[1]}; // [RL21]

		// Any access of the control/status register ends the mismatch
		if (status_access) begin
			next_state.last_seen = adjusted; // [RL15] [RL22]
		end

		// Register writes; sleep does not touch register contents
		if (reg_write) begin
			case (reg_addr)
				dcc_pkg::ADDR_CTRL_STATUS: begin
					// Result bits have no storage, so writes cannot reach them
					next_state.second_inv   = reg_wdata[dcc_pkg::SECOND_INV_BIT]; // [RL9] [RL3]
					next_state.first_inv    = reg_wdata[dcc_pkg::FIRST_INV_BIT]; // [RL3]
					next_state.input_switch = reg_wdata[dcc_pkg::INPUT_SWITCH_BIT]; // [RL4]
					next_state.comparator_mode_field =
						reg_wdata[dcc_pkg::MODE_LSB +: dcc_pkg::MODE_WIDTH]; // [RL5]
				end
				dcc_pkg::ADDR_IRQ_CONTROL: begin
					next_state.comparator_change_flag   = reg_wdata[dcc_pkg::FLAG_BIT]; // [RL13]
					next_state.comparator_change_enable = reg_wdata[dcc_pkg::CHANGE_ENABLE_BIT];
					next_state.peripheral_irq_enable    = reg_wdata[dcc_pkg::PERIPH_ENABLE_BIT];
					next_state.global_irq_enable        = reg_wdata[dcc_pkg::GLOBAL_ENABLE_BIT];
				end
				dcc_pkg::ADDR_DIRECTION: begin
					next_state.port_direction_bits = reg_wdata;
				end
				default: begin
				end
			endcase
		end

		// Mismatch set wins over a software clear in the same cycle,
		// so the read race is closed here rather than merely tolerated
		if (mismatch) begin
			next_state.comparator_change_flag = 1'b1; // [RL12] [RL15] [RL16]
		end

		// Read data stand in the cycle after the strobe only
		next_state.rdata = '0;
		if (reg_read) begin
			case (reg_addr)
				dcc_pkg::ADDR_CTRL_STATUS: next_state.rdata = status_value;
				dcc_pkg::ADDR_IRQ_CONTROL: next_state.rdata = irq_value;
				dcc_pkg::ADDR_DIRECTION:   next_state.rdata = state.port_direction_bits;
				dcc_pkg::ADDR_PORT_READ:   next_state.rdata = port_value;
				default:                   next_state.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state.sync_one                 <= '0;
		state.sync_two                 <= '0;
		state.last_seen                <= '0;
		state.second_inv               <= dcc_pkg::CTRL_RESET[dcc_pkg::SECOND_INV_BIT]; // [RL8]
		state.first_inv                <= dcc_pkg::CTRL_RESET[dcc_pkg::FIRST_INV_BIT];
		state.input_switch             <= dcc_pkg::CTRL_RESET[dcc_pkg::INPUT_SWITCH_BIT];
		state.comparator_mode_field    <= dcc_pkg::MODE_RESET; // [RL8]
		state.comparator_change_flag   <= dcc_pkg::IRQ_RESET[dcc_pkg::FLAG_BIT];
		state.comparator_change_enable <= dcc_pkg::IRQ_RESET[dcc_pkg::CHANGE_ENABLE_BIT];
		state.peripheral_irq_enable    <= dcc_pkg::IRQ_RESET[dcc_pkg::PERIPH_ENABLE_BIT];
		state.global_irq_enable        <= dcc_pkg::IRQ_RESET[dcc_pkg::GLOBAL_ENABLE_BIT];
		state.port_direction_bits      <= dcc_pkg::DIRECTION_RESET;
			state.rdata                    <= '0;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign reg_rdata = state.rdata;

	// Request needs all three enables; the flag itself ignores them
	assign irq_request = state.comparator_change_flag & state.comparator_change_enable
	                   & state.peripheral_irq_enable & state.global_irq_enable; // [RL14]

	// Wake needs only the comparator's own enable; core sleeps, block keeps running
	assign wake_request = sleep & state.comparator_change_flag
	                    & state.comparator_change_enable; // [RL17] [RL18]

	// Mode changes can glitch results; software masks the change enable meanwhile [RL19]

endmodule : dcc_top

// *** tb/dcc_partner.sv ***
// Behavioural pair of analog comparators on the far side of the block
`timescale 1ns/1ns
module dcc_partner (
	// Analog stimulus: bit set where the non-inverting input is higher
	input  wire logic [1:0] above,
	// Power enables from the block
	input  wire logic [1:0] comparator_power,
	// Raw comparator outputs
	output logic      [1:0] comparator_raw
);
	// Unpowered comparators float; shown high so missing gating shows up
	assign comparator_raw = (comparator_power & above) | ~comparator_power;
endmodule : dcc_partner

// *** tb/dcc_top_props.sv ***
// Port checker for the dual comparator control block
`timescale 1ns/1ns
module dcc_top_props #(
	parameter int SYNC_STAGES = 2
) (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] comparator_raw,
	input wire logic [1:0] comparator_power,
	input wire logic       noninv_vref_select,
	input wire logic       inverting_alt_select,
	input wire logic [7:0] analog_pin_mask,
	input wire logic [7:0] port_pin_in,
	input wire logic [1:0] result_pin_out,
	input wire logic [1:0] result_pin_oe,
	input wire logic       sleep,
	input wire logic       wake_request,
	input wire logic       irq_request
);
	logic [5:0] ctl_q;
	logic [2:1] dir_q;
	logic [3:0] en_q;
	wire        pin_mode = ctl_q[2:0] == 3'h3 || ctl_q[2:0] == 3'h5;
	// Shadow of the writable state, rebuilt from the register port
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctl_q <= 6'h00;
			dir_q <= 2'h3;
			en_q  <= 4'h0;
		end else if (reg_write) begin
			if (reg_addr == 2'h0) ctl_q <= reg_wdata[5:0];
			if (reg_addr == 2'h2) dir_q <= reg_wdata[2:1];
			if (reg_addr == 2'h1) en_q <= reg_wdata[3:0];
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	//////////////////////////////////////////////////////////////////////////////
	port_read_a: assert property (reg_read && reg_addr == 2'h3 |=>
		reg_rdata == $past(port_pin_in & ~analog_pin_mask)) else $error("port read wrong");
	vref_mode_a: assert property (noninv_vref_select == (ctl_q[2:0] == 3'h6))
		else $error("vref select wrong");
	alt_select_a: assert property (inverting_alt_select == (ctl_q == 6'h0e || ctl_q[3:0] == 4'he))
		else $error("input switch wrong");
	off_power_a: assert property (ctl_q[2:0] inside {3'h0, 3'h7} |-> comparator_power == 2'h0)
		else $error("comparator left powered");
	pin_drive_a: assert property (result_pin_out ==
		(pin_mode ? comparator_raw ^ ctl_q[5:4] : 2'h0)) else $error("result pin wrong");
	pin_oe_a: assert property (result_pin_oe == (pin_mode ? ~dir_q : 2'h0))
		else $error("pin enable wrong");
	irq_enable_a: assert property (irq_request |-> en_q[3:1] == 3'h7)
		else $error("request while disabled");
	wake_sleep_a: assert property (wake_request |-> sleep && en_q[1])
		else $error("wake while awake");
	result_sync_a: assert property ($stable(comparator_raw & comparator_power)[*4] ##0
		reg_read && reg_addr == 2'h0 |=> reg_rdata == {$past(comparator_raw & comparator_power)
		^ $past(ctl_q[5:4]), $past(ctl_q)}) else $error("status read wrong");
endmodule : dcc_top_props
bind dcc_top dcc_top_props #(.SYNC_STAGES(SYNC_STAGES)) chk (.core_clk, .rst, .reg_addr,
	.reg_wdata, .reg_write, .reg_read, .reg_rdata, .comparator_raw, .comparator_power,
	.noninv_vref_select, .inverting_alt_select, .analog_pin_mask, .port_pin_in,
	.result_pin_out, .result_pin_oe, .sleep, .wake_request, .irq_request);

// *** tb/test_dual_comparator_control.sv ***
// Self-checking bench for the dual comparator control block
`timescale 1ns/1ns
module test_dual_comparator_control;
	logic       core_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, sleep = 1'b0;
	logic [1:0] reg_addr = 2'h0, above = 2'h0, comparator_raw, comparator_power;
	logic [1:0] result_pin_out, result_pin_oe;
	logic [7:0] reg_wdata = 8'h00, port_pin_in = 8'hff, reg_rdata, analog_pin_mask;
	logic       noninv_vref_select, inverting_alt_select, wake_request, irq_request;
	int         bad_count = 0, comparisons = 0;
	always #2 core_clk = ~core_clk;
	dcc_partner partner (.above, .comparator_power, .comparator_raw);
	dcc_top #(.SYNC_STAGES(2)) uut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .comparator_raw, .comparator_power, .noninv_vref_select,
		.inverting_alt_select, .analog_pin_mask, .port_pin_in, .result_pin_out,
		.result_pin_oe, .sleep, .wake_request, .irq_request);
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
		@(posedge core_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1 chk(what, exp, reg_rdata);
	endtask : rd
	// Bounded wait; running out shows up as a mismatch
	task automatic wait_irq(input logic lvl);
		for (int n = 0; n < 10; n++) begin
			#1;
			if (irq_request === lvl) break;
			@(posedge core_clk);
		end
		chk("irq_request", {7'h0, lvl}, {7'h0, irq_request});
	endtask : wait_irq
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(2'h0, 8'h00, "status");
		rd(2'h2, 8'hff, "direction");
		rd(2'h3, 8'h81, "port read");
		chk("power", 8'h00, {6'h0, comparator_power});
	endtask : t_reset
	// Interrupts stay disabled while modes change, so no false request
	task automatic t_modes;
		logic [7:0] mask [8] = '{8'h7e, 8'h60, 8'h78, 8'h78, 8'h70, 8'h70, 8'h78, 8'h00};
		logic [1:0] pwr [8] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0};
		for (int m = 0; m < 8; m++) begin
			wr(2'h0, 8'(m));
			#1 chk("analog mask", mask[m], analog_pin_mask);
			chk("power", {6'h0, pwr[m]}, {6'h0, comparator_power});
			chk("vref", {7'h0, m == 6}, {7'h0, noninv_vref_select});
		end
		wr(2'h0, 8'h0e);
		#1 chk("alt select", 8'h01, {7'h0, inverting_alt_select});
	endtask : t_modes
	task automatic t_results;
		wr(2'h0, 8'h02);
		above <= 2'b01;
		repeat (4) @(posedge core_clk);
		rd(2'h0, 8'h42, "status");
		wr(2'h0, 8'hf2);
		rd(2'h0, 8'hb2, "status");
	endtask : t_results
	task automatic t_pins;
		wr(2'h2, 8'hf9);
		wr(2'h0, 8'h13);
		#1 chk("pin enables", 8'h03, {6'h0, result_pin_oe});
		chk("pin levels", 8'h00, {6'h0, result_pin_out});
		above <= 2'b10;
		#1 chk("pin levels", 8'h03, {6'h0, result_pin_out});
		wr(2'h2, 8'hfd);
		#1 chk("pin enables", 8'h01, {6'h0, result_pin_oe});
	endtask : t_pins
	task automatic t_flag;
		wr(2'h1, 8'h0e);
		wait_irq(1'b1);
		rd(2'h0, 8'hd3, "status");
		wr(2'h1, 8'h0e);
		wait_irq(1'b0);
		above <= 2'b11;
		wait_irq(1'b1);
		rd(2'h0, 8'h93, "status");
		wr(2'h1, 8'h0e);
		wait_irq(1'b0);
		wr(2'h1, 8'h0f);
		wait_irq(1'b1);
		wr(2'h1, 8'h07);
		wait_irq(1'b0);
		rd(2'h1, 8'h07, "irq control");
		@(posedge core_clk);
		sleep <= 1'b1;
		wr(2'h1, 8'h03);
		#1 chk("wake", 8'h01, {7'h0, wake_request});
		rd(2'h0, 8'h93, "status");
	endtask : t_flag
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_modes();
		t_results();
		t_pins();
		t_flag();
		conclude();
	end
	initial begin
		#20000;
		bad_count++;
		conclude();
	end
endmodule : test_dual_comparator_control
